/* File: hw/qdc_top.sv */
// Contract
// R1: Ten-bit control register: mode, ranges, inhibits, activate.
// R2: Range bit 0 unity, 1 double gain.
// R3: Mode bit picks single or double buffering.
// R4: Hardware activate pin acts without serial clock.
// R5: Inhibit set active; else needs activate and pin.
// R6: Two address bits pick channel 0 to 3.
// R7: Reset shuts down all four channels.
// R8: Reset control: mode 0, ranges 1, rest 0.
// R9: Shift bits only while input enable high.
// R10: Single mode updates on twelfth falling edge.
// R11: Double mode updates all on enable fall.
// R12: Single mode sticks until reset.
// R13: Top frame bit marks control versus data word.
`timescale 1ns/10ps
package qdc_pkg;
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] FRAME_LAST = 4'hB;
  localparam int CODE_BITS = 8;
  localparam int CHANNELS = 4;
  localparam int CTRL_BITS = 10;
  // Frame fields
  localparam int TYPE_POS = 11;
  localparam logic TYPE_CTRL = 1'h1;
  localparam int ADDR_MSB = 10;
  localparam int ADDR_LSB = 9;
  localparam int CODE_MSB = 7;
  // Control register fields
  localparam int MODE_POS = 9;
  localparam int RANGE_LSB = 5;
  localparam int SI_LSB = 1;
  localparam int ACT_POS = 0;
  localparam logic [9:0] CTRL_RESET = 10'h1E0;
  // Synchroniser lanes
  localparam int LANE_SCLK = 0;
  localparam int LANE_DATA = 1;
  localparam int LANE_EN = 2;
  localparam int LANE_HW = 3;
endpackage

module qdc_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic link_data_in,
  input wire logic link_en_in,
  input wire logic hw_activate_pin_in,
  output logic [9:0] converter_control_word_out,
  output logic [7:0] channel_0_code_out,
  output logic [7:0] channel_1_code_out,
  output logic [7:0] channel_2_code_out,
  output logic [7:0] channel_3_code_out,
  output logic [3:0] range_sel_out,
  output logic [3:0] chan_active_out,
  output logic buffer_single_out
);
  logic [3:0] sync_level;
  logic [3:0] sync_fall;
  logic [3:0] bit_cnt;
  logic [10:0] shift;
  logic [11:0] next_word;
  logic word_done;
  logic is_ctrl;
  logic [1:0] word_addr;
  logic [9:0] ctrl;
  logic [8:0] ctrl_fields;
  logic mode_single;
  logic single_now;
  logic update_single;
  logic update_double;
  logic [7:0] buf_code [0:3];
  logic [7:0] next_buf [0:3];
  logic [7:0] out_code [0:3];

  ////////////////////////////////////////////////////////////////////////
  // Link pins brought into the system clock
  // Two flops of lag per pin: link clock phases must last three clocks
  qdc_sync #(.WIDTH(4)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({hw_activate_pin_in, link_en_in, link_data_in, link_clk_in}),
    .level_out(sync_level),
    .fall_out(sync_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial shifter
  // Eleven earlier bits sit in shift; the last one comes from the lane directly
  assign next_word = {shift, sync_level[qdc_pkg::LANE_DATA]};
  // R9: gated by enable
  assign word_done = sync_level[qdc_pkg::LANE_EN] && sync_fall[qdc_pkg::LANE_SCLK]
    && (bit_cnt == qdc_pkg::FRAME_LAST);
  // R13: word type bit
  assign is_ctrl = (next_word[qdc_pkg::TYPE_POS] == qdc_pkg::TYPE_CTRL);
  // Bit 8 of a data word is ignored: range comes only from control words
  assign word_addr = next_word[qdc_pkg::ADDR_MSB:qdc_pkg::ADDR_LSB];

  // R9: enable low drops any partial frame
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt <= '0;
      shift <= '0;
    end else if (!sync_level[qdc_pkg::LANE_EN]) begin
      bit_cnt <= '0;
    end else if (sync_fall[qdc_pkg::LANE_SCLK]) begin
      shift <= next_word[qdc_pkg::FRAME_BITS-2:0];
      bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register
  // R1: ten-bit register written by control words
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      // R8: power-on defaults
      ctrl_fields <= qdc_pkg::CTRL_RESET[qdc_pkg::MODE_POS-1:0];
    end else if (word_done && is_ctrl) begin
      ctrl_fields <= next_word[qdc_pkg::MODE_POS-1:0];
    end
  end

  // Sticky so a stray control word cannot undo single mode
  // R12: mode can be set but only reset clears it
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mode_single <= qdc_pkg::CTRL_RESET[qdc_pkg::MODE_POS];
    end else if (word_done && is_ctrl && next_word[qdc_pkg::MODE_POS]) begin
      mode_single <= 1'h1;
    end
  end

  assign ctrl = {mode_single, ctrl_fields};

  // A control word that selects single mode already latches on its own last edge
  assign single_now = ctrl[qdc_pkg::MODE_POS]
    | (is_ctrl & next_word[qdc_pkg::MODE_POS]);
  // R10: single mode updates at word end
  assign update_single = word_done && single_now;
  // A word end needs enable high, so it never meets an enable fall
  // R11: double mode updates on enable fall
  assign update_double = sync_fall[qdc_pkg::LANE_EN] && !ctrl[qdc_pkg::MODE_POS];

  ////////////////////////////////////////////////////////////////////////
  // Per-channel input buffer and output latch
  genvar ch;
  generate
    for (ch = 0; ch < qdc_pkg::CHANNELS; ch++) begin : g_chan
      // R6: address decode, later word overwrites
      always_comb begin
        next_buf[ch] = buf_code[ch];
        if (!is_ctrl && (word_addr == 2'(ch))) begin
          next_buf[ch] = next_word[qdc_pkg::CODE_MSB:0];
        end
      end

      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          buf_code[ch] <= '0;
        end else if (word_done) begin
          buf_code[ch] <= next_buf[ch];
        end
      end

      // Double update is gated off in single mode, so the order is moot
      // R3: buffering mode picks the update moment
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          out_code[ch] <= '0;
        end else if (update_single) begin
          out_code[ch] <= next_buf[ch];
        end else if (update_double) begin
          out_code[ch] <= buf_code[ch];
        end
      end

      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          // R7: all channels shut down
          chan_active_out[ch] <= 1'h0;
        end else begin
          // Synchronised pin: a few clocks of lag, never a serial edge
          // R4: synchronised pin used, no serial edge needed
          // R5: inhibit forces active, else both activates
          chan_active_out[ch] <= ctrl[qdc_pkg::SI_LSB + ch]
            | (ctrl[qdc_pkg::ACT_POS] & sync_level[qdc_pkg::LANE_HW]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Codes reset to zero together with the channel latches
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      channel_0_code_out <= '0;
      channel_1_code_out <= '0;
      channel_2_code_out <= '0;
      channel_3_code_out <= '0;
    end else begin
      channel_0_code_out <= out_code[0];
      channel_1_code_out <= out_code[1];
      channel_2_code_out <= out_code[2];
      channel_3_code_out <= out_code[3];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      converter_control_word_out <= qdc_pkg::CTRL_RESET;
      range_sel_out <= qdc_pkg::CTRL_RESET[qdc_pkg::RANGE_LSB +: qdc_pkg::CHANNELS];
      buffer_single_out <= 1'h0;
    end else begin
      converter_control_word_out <= ctrl;
      // R2: range bit 1 means double gain
      range_sel_out <= ctrl[qdc_pkg::RANGE_LSB +: qdc_pkg::CHANNELS];
      buffer_single_out <= ctrl[qdc_pkg::MODE_POS];
    end
  end
endmodule

/* File: hw/qdc_sync.sv */
`timescale 1ns/10ps
module qdc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level_out = stable;
  assign fall_out = prev & ~stable;
endmodule

/* File: tb/qdc_chk.sv */
`timescale 1ns/10ps
module qdc_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic link_en_in,
  input wire logic hw_activate_pin_in,
  input wire logic [9:0] converter_control_word_out,
  input wire logic [7:0] channel_0_code_out,
  input wire logic [3:0] range_sel_out,
  input wire logic [3:0] chan_active_out,
  input wire logic buffer_single_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire [9:0] cw = converter_control_word_out;
  ////////////////////////////////////////
  chk_range_copy: assert property (range_sel_out == cw[8:5])
    else $error("range");
  chk_mode_copy: assert property (buffer_single_out == cw[9])
    else $error("mode");
  chk_mode_sticky: assert property (buffer_single_out |=> buffer_single_out)
    else $error("mode cleared");
  // Six quiet cycles cover pin sync plus output register
  chk_active_map: assert property (($stable(cw) && $stable(hw_activate_pin_in))[*6] |->
    chan_active_out == (cw[4:1] | {4{cw[0] & hw_activate_pin_in}})) else $error("active");
  // Second reset edge: flops settled whether reset came with or before the clock
  chk_reset_vals: assert property (disable iff (1'b0) rst_in && $past(rst_in) |->
    cw == 10'h1E0 && chan_active_out == 4'h0) else $error("reset");
  chk_pin_rise: assert property (cw[0] && $rose(hw_activate_pin_in) |->
    ##[1:6] chan_active_out == 4'hF) else $error("pin rise");
  chk_pin_fall: assert property ($fell(hw_activate_pin_in) |->
    ##[1:6] chan_active_out == cw[4:1]) else $error("pin fall");
  chk_code_on_en: assert property ($changed(channel_0_code_out) |->
    (!link_en_in) or (##[0:1] buffer_single_out)) else $error("code early");
  cover property (buffer_single_out);
  cover property ($rose(chan_active_out[0]));
  cover property ($changed(channel_0_code_out));
endmodule
bind qdc_top qdc_chk i_qdc_chk (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .link_en_in(link_en_in),
  .hw_activate_pin_in(hw_activate_pin_in),
  .converter_control_word_out(converter_control_word_out),
  .channel_0_code_out(channel_0_code_out),
  .range_sel_out(range_sel_out),
  .chan_active_out(chan_active_out),
  .buffer_single_out(buffer_single_out)
);

/* File: tb/qdc_host.sv */
`timescale 1ns/10ps
module qdc_host (
  output logic link_clk_out,
  output logic link_data_out,
  output logic link_en_out
);
  initial begin
    link_clk_out = 1'b0;
    link_data_out = 1'b0;
    link_en_out = 1'b0;
  end
  // word MSB first, clock idles low
  task automatic send(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      link_clk_out = 1'b1;
      link_data_out = w[i];
      #200 link_clk_out = 1'b0;
      #200;
    end
    // Released line must not look like held data
    link_data_out = ~w[0];
    // A following word must not reassign the line in the same step
    #50;
  endtask
  task automatic enable(input logic lvl);
    link_en_out = lvl;
    #400;
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_in;
  logic rst_in;
  logic hw_activate_pin_in;
  logic link_clk_in, link_data_in, link_en_in, buffer_single_out;
  logic [9:0] converter_control_word_out;
  logic [7:0] channel_0_code_out, channel_1_code_out, channel_2_code_out, channel_3_code_out;
  logic [3:0] range_sel_out, chan_active_out;
  wire [9:0] cw = converter_control_word_out;
  wire [31:0] codes = {channel_3_code_out, channel_2_code_out, channel_1_code_out,
    channel_0_code_out};
  int fails = 0, checks = 0, cycles = 0;
  initial begin
    clk_sys_in = 1'h0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  qdc_host i_qdc_host (.link_clk_out(link_clk_in), .link_data_out(link_data_in),
    .link_en_out(link_en_in));
  qdc_top i_qdc_top (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .link_clk_in(link_clk_in),
    .link_data_in(link_data_in),
    .link_en_in(link_en_in),
    .hw_activate_pin_in(hw_activate_pin_in),
    .converter_control_word_out(converter_control_word_out),
    .channel_0_code_out(channel_0_code_out),
    .channel_1_code_out(channel_1_code_out),
    .channel_2_code_out(channel_2_code_out),
    .channel_3_code_out(channel_3_code_out),
    .range_sel_out(range_sel_out),
    .chan_active_out(chan_active_out),
    .buffer_single_out(buffer_single_out)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    rst_in = 1'h1;
    hw_activate_pin_in = 1'h0;
    idle(16);
    rst_in = 1'b0;
    idle(2);
    chk({chan_active_out, range_sel_out, buffer_single_out, cw}, 19'h079E0);
    i_qdc_host.send(12'h8FF);
    idle(10);
    chk(cw, 10'h1E0);
    $display("test 1 done");
    i_qdc_host.enable(1'b1);
    i_qdc_host.send(12'h0FF);
    for (int a = 0; a < 4; a++) i_qdc_host.send({1'b0, 2'(a), 1'b0, 8'(17 * (a + 1))});
    idle(10);
    chk(codes, 32'h0);
    i_qdc_host.enable(1'b0);
    idle(10);
    chk(codes, 32'h44332211);
    $display("test 2 done");
    i_qdc_host.enable(1'b1);
    i_qdc_host.send(12'h8A5);
    i_qdc_host.enable(1'b0);
    idle(10);
    chk({chan_active_out, range_sel_out, cw}, 18'h094A5);
    hw_activate_pin_in = 1'b1;
    idle(10);
    chk(chan_active_out, 4'hF);
    hw_activate_pin_in = 1'b0;
    idle(10);
    chk(chan_active_out, 4'h2);
    $display("test 3 done");
    i_qdc_host.enable(1'b1);
    i_qdc_host.send(12'hA00);
    idle(10);
    chk({range_sel_out, buffer_single_out, cw}, 15'h0600);
    i_qdc_host.send(12'h45A);
    idle(10);
    chk(channel_2_code_out, 8'h5A);
    i_qdc_host.send(12'h800);
    idle(10);
    chk(cw, 10'h200);
    i_qdc_host.enable(1'b0);
    $display("test 4 done");
    rst_in = 1'h1;
    idle(4);
    rst_in = 1'h0;
    idle(2);
    chk({chan_active_out, range_sel_out, buffer_single_out, cw}, 19'h079E0);
    chk(codes, 32'h0);
    $display("test 5 done");
    test_done();
  end
endmodule
